// ==== rtl/mute_top.sv ====
// Four-sensor muting block with error latch, release logic and APB registers.
// Operation
// - Muting error latched until valid cycle completes.
// - Clear by override, or free then sequence.
// - Error output low only without other errors.
// - Error forces release low, flag high.
// - Error on simultaneity, total time, direction.
// - Sequence and gap faults set both the diagnostic error and the muting error.
// - Cycle starts when first reached pair active.
// - Handover only while all four active.
// - Muting holds while second pair active.
// - Bypass from first pair until second free.
// - Qualifier must precede first pair fully active.
// - Both directions or fixed direction selectable.
// - Simultaneity, total time, safety-end configurable.
// - Release on muting, override or free.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none
`include "mute_cfg.svh"
module mute_top
  import mute_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  input  wire logic        FIRST_PAIR_SENSOR_ONE_I,
  input  wire logic        FIRST_PAIR_SENSOR_TWO_I,
  input  wire logic        SECOND_PAIR_SENSOR_ONE_I,
  input  wire logic        SECOND_PAIR_SENSOR_TWO_I,
  input  wire logic        DIRECTION_QUALIFY_INPUT_I,
  input  wire logic        SAFETY_SWITCHING_OUTPUT_I,
  input  wire logic        OVERRIDE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [31:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             RELEASE_O,
  output logic             MUTING_ERROR_O,
  output logic             ERROR_FLAG_O,
  output logic             MUTING_ACTIVE_O,
  output logic             IRQ_O
);
  // ************************************************************
  // States
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FIRST = 5'b00010,
    ST_ALL   = 5'b00100,
    ST_SECND = 5'b01000,
    ST_WAIT  = 5'b10000
  } mstate_t;
  typedef struct packed {
    mstate_t    st;
    logic       rev;
    logic       qual_seen;
    logic       mute_err;
    logic       diag_err;
    logic       all_free;
    logic       rel;
    logic       err_out;
    logic       flag;
    logic       act;
    logic       rdy;
    logic [`NUM_EV-1:0] ev;
  } top_t;
  top_t       s_r;
  top_t       s_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;
  assign rst_n = rst_sync_r[1];
  // ************************************************************
  // Decode functions
  // ************************************************************
  function automatic logic pair_full(input logic one, input logic two);
    return one & two;
  endfunction
  function automatic logic pair_part(input logic one, input logic two);
    return one ^ two;
  endfunction
  function automatic logic in_cycle(input mstate_t st);
    return (st == ST_FIRST) || (st == ST_ALL) || (st == ST_SECND);
  endfunction
  function automatic logic dir_allowed(input dir_mode_t mode, input logic rev);
    logic ok;
    ok = 1'b1;
    if (mode == DIR_FWD && rev) begin
      ok = 1'b0;
    end
    if (mode == DIR_REV && !rev) begin
      ok = 1'b0;
    end
    return ok;
  endfunction
  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  // ************************************************************
  // Registers and timers
  // ************************************************************
  logic [7:0]  ctrl;
  logic [31:0] simul_lim;
  logic [31:0] total_lim;
  logic        simul_exp;
  logic        total_exp;
  logic        pslverr;
  bus_req_t    req;
  assign req = '{addr:  PADDR_I,
                 wr:    PWRITE_I,
                 en:    PENABLE_I,
                 wdata: PWDATA_I};
  mute_apb u_apb (
    .clk_i     (CLOCK_I),
    .rst_n_i   (rst_n),
    .ce_i      (CE_I),
    .req_i     (req),
    .psel_i    (PSEL_I),
    .ev_i      (s_r.ev),
    .state_i   ({s_r.st, s_r.mute_err, s_r.diag_err, s_r.rev}),
    .prdata_o  (PRDATA_O),
    .pslverr_o (pslverr),
    .ctrl_o    (ctrl),
    .simul_o   (simul_lim),
    .total_o   (total_lim),
    .irq_o     (IRQ_O)
  );
  // ************************************************************
  // Sensor decode
  // ************************************************************
  sens_t s;
  assign s = '{p1a:       FIRST_PAIR_SENSOR_ONE_I,
               p1b:       FIRST_PAIR_SENSOR_TWO_I,
               p2a:       SECOND_PAIR_SENSOR_ONE_I,
               p2b:       SECOND_PAIR_SENSOR_TWO_I,
               qual:      DIRECTION_QUALIFY_INPUT_I,
               safe_free: SAFETY_SWITCHING_OUTPUT_I,
               ovr:       OVERRIDE_I};
  logic      a_any;
  logic      a_both;
  logic      b_any;
  logic      b_both;
  dir_mode_t dmode;
  assign a_both = pair_full(s.p1a, s.p1b);
  assign a_any  = s.p1a | s.p1b;
  assign b_both = pair_full(s.p2a, s.p2b);
  assign b_any  = s.p2a | s.p2b;
  assign dmode  = dir_mode_t'(ctrl[`CTRL_DIR_LO+1:`CTRL_DIR_LO]);
  // ************************************************************
  // Timers
  // ************************************************************
  // Simultaneity: one sensor of either pair active without its partner, while idle.
  logic lead_part;
  assign lead_part = (s_r.st == ST_IDLE) && (pair_part(s.p1a, s.p1b) || pair_part(s.p2a, s.p2b));
  mute_timer u_simul (
    .clk_i     (CLOCK_I),
    .rst_n_i   (rst_n),
    .ce_i      (CE_I),
    .run_i     (lead_part & ctrl[`CTRL_EN_SIMUL]),
    .limit_i   (simul_lim),
    .expired_o (simul_exp)
  );
  mute_timer u_total (
    .clk_i     (CLOCK_I),
    .rst_n_i   (rst_n),
    .ce_i      (CE_I),
    .run_i     (in_cycle(s_r.st) && ctrl[`CTRL_EN_TOTAL]),
    .limit_i   (total_lim),
    .expired_o (total_exp)
  );
  // ************************************************************
  // Sequence logic
  // ************************************************************
  logic lead_both;
  logic trail_both;
  logic trail_any;
  logic dir_ok;
  logic fault;
  logic seq_done;
  always_comb begin
    lead_both  = s_r.rev ? b_both : a_both;
    trail_both = s_r.rev ? a_both : b_both;
    trail_any  = s_r.rev ? a_any : b_any;
    dir_ok     = 1'b1;
    fault      = 1'b0;
    seq_done   = 1'b0;
    s_nxt      = s_r;
    s_nxt.ev   = '0;
    s_nxt.rdy  = PSEL_I & ~PENABLE_I;
    if (s.qual && ctrl[`CTRL_USE_QUAL]) begin
      s_nxt.qual_seen = 1'b1;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (a_both || b_both) begin
          s_nxt.rev = b_both && !a_both;
          dir_ok = dir_allowed(dmode, s_nxt.rev);
          if (ctrl[`CTRL_USE_QUAL] && !s_r.qual_seen) dir_ok = 1'b0;
          if (dir_ok) begin
            s_nxt.st = ST_FIRST;
          end else begin
            s_nxt.ev[`EV_DIR] = 1'b1;
            s_nxt.st = ST_WAIT;
          end
        end else if (simul_exp) begin
          s_nxt.ev[`EV_SIMUL] = 1'b1;
          s_nxt.st = ST_WAIT;
        end else if (trail_any && ctrl[`CTRL_EN_SEQ]) begin
          s_nxt.ev[`EV_SEQ] = 1'b1;
        end
      end
      ST_FIRST: begin
        if (lead_both && trail_both) begin
          s_nxt.st = ST_ALL;
        end else if (!lead_both) begin
          s_nxt.ev[`EV_GAP] = 1'b1;
          s_nxt.st = ST_WAIT;
        end
      end
      ST_ALL: begin
        if (trail_both && !lead_both) begin
          s_nxt.st = ST_SECND;
        end else if (!trail_both) begin
          s_nxt.ev[`EV_SEQ] = 1'b1;
          s_nxt.st = ST_WAIT;
        end
      end
      ST_SECND: begin
        if (!trail_both) begin
          seq_done = 1'b1;
          s_nxt.st = ST_IDLE;
          s_nxt.qual_seen = 1'b0;
        end else if (lead_both) begin
          s_nxt.ev[`EV_SEQ] = 1'b1;
          s_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!a_any && !b_any) begin
          s_nxt.st = ST_IDLE;
          s_nxt.qual_seen = 1'b0;
        end
      end
      default: s_nxt.st = ST_WAIT;
    endcase
    if (total_exp && s_r.st != ST_WAIT) begin
      s_nxt.ev[`EV_TOTAL] = 1'b1;
      s_nxt.st = ST_WAIT;
    end
    if (ctrl[`CTRL_EN_SDEND] && s.safe_free && (s_r.st == ST_SECND)) begin
      s_nxt.st = ST_IDLE;
      seq_done = 1'b1;
    end
    fault = |s_nxt.ev[`EV_GAP:`EV_SIMUL];
    s_nxt.all_free = (!a_any && !b_any && s.safe_free) || (s_r.all_free && !fault && !seq_done);
    s_nxt.diag_err = s_nxt.ev[`EV_SEQ] | s_nxt.ev[`EV_GAP] | (s_r.diag_err & !seq_done & !s.ovr);
    if (fault) begin
      s_nxt.mute_err = 1'b1;
    end else if (s_r.mute_err && (s.ovr || (seq_done && s_r.all_free)) && !s_nxt.diag_err) begin
      s_nxt.mute_err = 1'b0;
      s_nxt.ev[`EV_DONE] = 1'b1;
    end
    s_nxt.act = in_cycle(s_nxt.st);
    s_nxt.err_out = s_nxt.mute_err;
    s_nxt.flag = s_nxt.mute_err | s_nxt.diag_err;
    s_nxt.rel = !s_nxt.flag && (s_nxt.act || s.ovr || s.safe_free);
  end
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: ST_IDLE, default: '0};
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end
  // ************************************************************
  // Outputs
  // ************************************************************
  assign PREADY_O        = s_r.rdy;
  assign PSLVERR_O       = pslverr;
  assign RELEASE_O       = s_r.rel;
  assign MUTING_ERROR_O  = s_r.err_out;
  assign ERROR_FLAG_O    = s_r.flag;
  assign MUTING_ACTIVE_O = s_r.act;
endmodule
`default_nettype wire

// ==== rtl/mute_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the muting block.
`ifndef MUTE_CFG_SVH
`define MUTE_CFG_SVH
`define OFF_CTRL        8'h00
`define OFF_SIMUL       8'h04
`define OFF_TOTAL       8'h08
`define OFF_STATUS      8'h0c
`define OFF_INT_STAT    8'h10
`define OFF_INT_MASK    8'h14
`define OFF_STATE       8'h18
`define CTRL_EN_SIMUL   0
`define CTRL_EN_TOTAL   1
`define CTRL_EN_SDEND   2
`define CTRL_DIR_LO     3
`define CTRL_USE_QUAL   5
`define CTRL_EN_SEQ     6
`define CTRL_RST        8'h00
`define SIMUL_MS        3
`define CLK_KHZ         10000
`define SIMUL_RST       32'((`SIMUL_MS * `CLK_KHZ))
`define TOTAL_S         60
`define TOTAL_RST       32'(`TOTAL_S * `CLK_KHZ * 1000)
`define EV_SIMUL        0
`define EV_TOTAL        1
`define EV_DIR          2
`define EV_SEQ          3
`define EV_GAP          4
`define EV_DONE         5
`define NUM_EV          6
`endif

// ==== rtl/mute_pkg.sv ====
// Types shared by the muting block.
`default_nettype none
package mute_pkg;
  typedef enum logic [1:0] {
    DIR_BOTH = 2'h0,
    DIR_FWD  = 2'h1,
    DIR_REV  = 2'h2
  } dir_mode_t;
  typedef struct packed {
    logic p1a;
    logic p1b;
    logic p2a;
    logic p2b;
    logic qual;
    logic safe_free;
    logic ovr;
  } sens_t;
  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    logic        en;
    logic [31:0] wdata;
  } bus_req_t;
endpackage
`default_nettype wire

// ==== rtl/mute_timer.sv ====
// Up counter that flags expiry of a programmed time while running.
`default_nettype none
module mute_timer
  import mute_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        run_i,
  input  wire logic [31:0] limit_i,
  output logic             expired_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        exp;
  } tmr_t;
  tmr_t s_r;
  tmr_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (!run_i) begin
      s_nxt.cnt = '0;
      s_nxt.exp = 1'b0;
    end else if (s_r.cnt >= limit_i) begin
      s_nxt.exp = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
  assign expired_o = s_r.exp;
endmodule
`default_nettype wire

// ==== rtl/mute_apb.sv ====
// APB slave holding configuration, sticky event status and mask.
`default_nettype none
`include "mute_cfg.svh"
module mute_apb
  import mute_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  input  wire bus_req_t            req_i,
  input  wire logic                psel_i,
  input  wire logic [`NUM_EV-1:0]  ev_i,
  input  wire logic [7:0]          state_i,
  output logic [31:0]              prdata_o,
  output logic                     pslverr_o,
  output logic [7:0]               ctrl_o,
  output logic [31:0]              simul_o,
  output logic [31:0]              total_o,
  output logic                     irq_o
);
  typedef struct packed {
    logic [7:0]         ctrl;
    logic [31:0]        simul;
    logic [31:0]        total;
    logic [`NUM_EV-1:0] stat;
    logic [`NUM_EV-1:0] mask;
    logic [31:0]        rdata;
    logic               err;
    logic               irq;
  } regs_t;
  regs_t s_r;
  regs_t s_nxt;
  logic  acc;
  logic  setup;
  logic  hit;
  assign acc   = psel_i & req_i.en;
  assign setup = psel_i & ~req_i.en;
  assign hit   = (req_i.addr[31:8] == 24'h0);
  always_comb begin
    s_nxt = s_r;
    s_nxt.err = 1'b0;
    if (acc && req_i.wr && hit) begin
      unique case (req_i.addr[7:0])
        `OFF_CTRL:     s_nxt.ctrl = req_i.wdata[7:0];
        `OFF_SIMUL:    s_nxt.simul = req_i.wdata;
        `OFF_TOTAL:    s_nxt.total = req_i.wdata;
        `OFF_INT_STAT: s_nxt.stat = s_r.stat & ~req_i.wdata[`NUM_EV-1:0];
        `OFF_INT_MASK: s_nxt.mask = req_i.wdata[`NUM_EV-1:0];
        default:       ;
      endcase
    end
    if (setup) begin
      unique case (req_i.addr[7:0])
        `OFF_CTRL:     s_nxt.rdata = {24'h0, s_r.ctrl};
        `OFF_SIMUL:    s_nxt.rdata = s_r.simul;
        `OFF_TOTAL:    s_nxt.rdata = s_r.total;
        `OFF_STATUS:   s_nxt.rdata = {24'h0, state_i};
        `OFF_INT_STAT: s_nxt.rdata = {26'h0, s_r.stat};
        `OFF_INT_MASK: s_nxt.rdata = {26'h0, s_r.mask};
        `OFF_STATE:    s_nxt.rdata = {24'h0, state_i};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.err = 1'b1;
        end
      endcase
      if (!hit) begin
        s_nxt.rdata = 32'h0;
        s_nxt.err = 1'b1;
      end
    end
    s_nxt.stat = s_nxt.stat | ev_i;
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{ctrl: `CTRL_RST, simul: `SIMUL_RST, total: `TOTAL_RST, default: '0};
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
  assign prdata_o  = s_r.rdata;
  assign pslverr_o = s_r.err;
  assign ctrl_o    = s_r.ctrl;
  assign simul_o   = s_r.simul;
  assign total_o   = s_r.total;
  assign irq_o     = s_r.irq;
endmodule
`default_nettype wire

// ==== verif/mute_sensor_model.sv ====
// Model of the muting sensors and the safety device outputs.
`default_nettype none
module mute_sensor_model
  import mute_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [2:0] phase_i,
  input  wire logic       qual_i,
  input  wire logic       safe_i,
  input  wire logic       ovr_i,
  output var sens_t       sens_o
);
  logic [3:0] pat;
  // Phase 1 is one sensor of the first pair, 2 the first pair, 3 all four, 4 the second pair.
  always_comb begin
    case (phase_i)
      3'h1:    pat = 4'h8;
      3'h2:    pat = 4'hc;
      3'h3:    pat = 4'hf;
      3'h4:    pat = 4'h3;
      default: pat = 4'h0;
    endcase
  end
  // The qualifier is registered with the pattern, one cycle after the bench raises it, ahead of the pair.
  always_ff @(posedge clk_i) begin
    sens_o <= {pat, qual_i, safe_i, ovr_i};
  end
endmodule
`default_nettype wire

// ==== verif/mute_top_checker.sv ====
// Port-level checker for the muting block.
`default_nettype none
module mute_top_checker (
  input wire logic        CLOCK_I,
  input wire logic        NRST_I,
  input wire logic        FIRST_PAIR_SENSOR_ONE_I,
  input wire logic        FIRST_PAIR_SENSOR_TWO_I,
  input wire logic        SECOND_PAIR_SENSOR_ONE_I,
  input wire logic        SECOND_PAIR_SENSOR_TWO_I,
  input wire logic        OVERRIDE_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        RELEASE_O,
  input wire logic        MUTING_ERROR_O,
  input wire logic        ERROR_FLAG_O,
  input wire logic        MUTING_ACTIVE_O
);
  wire logic a_both = FIRST_PAIR_SENSOR_ONE_I && FIRST_PAIR_SENSOR_TWO_I;
  wire logic b_both = SECOND_PAIR_SENSOR_ONE_I && SECOND_PAIR_SENSOR_TWO_I;
  wire logic idle   = !(FIRST_PAIR_SENSOR_ONE_I || FIRST_PAIR_SENSOR_TWO_I || SECOND_PAIR_SENSOR_ONE_I
                        || SECOND_PAIR_SENSOR_TWO_I || OVERRIDE_I);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);
  sequence s_quiet;
    idle [*3];
  endsequence
  sequence s_pair_seen;
    $past(a_both || b_both);
  endsequence
  a_err_blocks_release: assert property (MUTING_ERROR_O |-> !RELEASE_O)
    else $error("release high during muting error");
  a_err_sets_flag: assert property (MUTING_ERROR_O |-> ERROR_FLAG_O)
    else $error("error flag low during muting error");
  a_release_clean: assert property (RELEASE_O |-> !ERROR_FLAG_O)
    else $error("release high with an error state");
  a_ready_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("bus not ready in access phase");
  a_unmapped_refused: assert property (PSEL_I && PENABLE_I |->
    PSLVERR_O == ((PADDR_I > 32'h18) || (PADDR_I[1:0] != 2'h0)))
    else $error("slave error does not match address map");
  a_mute_start: assert property ($rose(MUTING_ACTIVE_O) |-> s_pair_seen)
    else $error("muting started without a full pair");
  a_quiet_ends: assert property (s_quiet |-> !MUTING_ACTIVE_O)
    else $error("muting active with all sensors free");
  a_err_latched: assert property (MUTING_ERROR_O && a_both && b_both && !OVERRIDE_I |=> MUTING_ERROR_O)
    else $error("muting error dropped in mid-cycle");
endmodule
bind mute_top mute_top_checker u_chk (.CLOCK_I, .NRST_I, .FIRST_PAIR_SENSOR_ONE_I, .FIRST_PAIR_SENSOR_TWO_I,
  .SECOND_PAIR_SENSOR_ONE_I, .SECOND_PAIR_SENSOR_TWO_I, .OVERRIDE_I, .PSEL_I, .PENABLE_I, .PADDR_I,
  .PREADY_O, .PSLVERR_O, .RELEASE_O, .MUTING_ERROR_O, .ERROR_FLAG_O, .MUTING_ACTIVE_O);
`default_nettype wire

// ==== verif/mute_tb_top.sv ====
// Self-checking bench for the muting block.
`default_nettype none
`include "mute_cfg.svh"
module four_sensor_muting_logic_tb_top
  import mute_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, psel, penable, pwrite, qual, safe, ovr, pready, pslverr, errv, i0;
  logic        rel, merr, eflag, mact, irq, ce;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic [2:0]  phase;
  sens_t       sens;
  int          bad_count, samples_checked;
  mute_sensor_model u_far (.clk_i(clk), .phase_i(phase), .qual_i(qual), .safe_i(safe), .ovr_i(ovr), .sens_o(sens));
  mute_top dut (.CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce), .FIRST_PAIR_SENSOR_ONE_I(sens.p1a),
    .FIRST_PAIR_SENSOR_TWO_I(sens.p1b), .SECOND_PAIR_SENSOR_ONE_I(sens.p2a), .SECOND_PAIR_SENSOR_TWO_I(sens.p2b),
    .DIRECTION_QUALIFY_INPUT_I(sens.qual), .SAFETY_SWITCHING_OUTPUT_I(sens.safe_free), .OVERRIDE_I(sens.ovr),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RELEASE_O(rel), .MUTING_ERROR_O(merr), .ERROR_FLAG_O(eflag),
    .MUTING_ACTIVE_O(mact), .IRQ_O(irq));
  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rdv, exp);
  endtask
  task automatic ph(input logic [2:0] p, input int n);
    phase <= p;
    cyc(n);
  endtask
  task automatic seq();
    ph(3'h2, 6);
    ph(3'h3, 6);
    ph(3'h4, 6);
    ph(3'h0, 6);
  endtask
  task automatic tidy();
    ovr <= 1'b1;
    cyc(6);
    ovr <= 1'b0;
    ph(3'h0, 6);
    apb(1'b1, `OFF_INT_STAT, 32'h3f);
    apb(1'b1, `OFF_CTRL, 32'h0);
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_regs();
    rchk("ctrl reset", `OFF_CTRL, 32'(`CTRL_RST));
    rchk("simul reset", `OFF_SIMUL, `SIMUL_RST);
    rchk("total reset", `OFF_TOTAL, `TOTAL_RST);
    apb(1'b0, 32'h40, 32'h0);
    chk("unmapped error", 32'(errv), 32'h1);
  endtask
  task automatic t_cycle();
    ph(3'h0, 6);
    chk("release blocked", 32'(rel), 32'h0);
    ce <= 1'b0;
    ph(3'h2, 6);
    chk("frozen by enable", 32'(mact), 32'h0);
    ce <= 1'b1;
    cyc(6);
    chk("mute on", 32'(mact), 32'h1);
    chk("release muting", 32'(rel), 32'h1);
    ph(3'h3, 6);
    ph(3'h4, 6);
    chk("second pair holds", 32'(mact), 32'h1);
    ph(3'h0, 6);
    chk("mute off", 32'(mact), 32'h0);
    chk("no error", 32'(merr), 32'h0);
    safe <= 1'b1;
    cyc(6);
    chk("release free", 32'(rel), 32'h1);
    safe <= 1'b0;
  endtask
  task automatic t_simul();
    apb(1'b1, `OFF_SIMUL, 32'h5);
    apb(1'b1, `OFF_CTRL, 32'h1);
    ph(3'h1, 20);
    ph(3'h2, 6);
    chk("simul error", 32'(merr), 32'h1);
    chk("release forced", 32'(rel), 32'h0);
    chk("flag raised", 32'(eflag), 32'h1);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk("simul event", 32'(rdv[`EV_SIMUL]), 32'h1);
    apb(1'b1, `OFF_INT_MASK, 32'h0);
    cyc(2);
    i0 = irq;
    apb(1'b1, `OFF_INT_MASK, 32'h3f);
    cyc(2);
    chk("irq mask", 32'(irq ^ i0), 32'h1);
    ph(3'h3, 6);
    ph(3'h4, 6);
    ph(3'h0, 6);
    chk("error kept", 32'(merr), 32'h1);
    safe <= 1'b1;
    cyc(6);
    seq();
    chk("error cleared", 32'(merr), 32'h0);
    chk("flag cleared", 32'(eflag), 32'h0);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk("done event", 32'(rdv[`EV_DONE]), 32'h1);
    safe <= 1'b0;
    apb(1'b1, `OFF_INT_STAT, 32'h3f);
    rchk("status clear", `OFF_INT_STAT, 32'h0);
    chk("irq low", 32'(irq), 32'h0);
    tidy();
  endtask
  task automatic t_total();
    apb(1'b1, `OFF_TOTAL, 32'ha);
    apb(1'b1, `OFF_CTRL, 32'h2);
    ph(3'h2, 30);
    chk("total error", 32'(merr), 32'h1);
    ph(3'h0, 6);
    ovr <= 1'b1;
    cyc(6);
    ovr <= 1'b0;
    cyc(6);
    chk("override clear", 32'(merr), 32'h0);
    tidy();
  endtask
  task automatic t_dir();
    apb(1'b1, `OFF_CTRL, 32'h8);
    ph(3'h4, 6);
    chk("wrong way", 32'(mact), 32'h0);
    ph(3'h0, 6);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk("dir event", 32'(rdv[`EV_DIR]), 32'h1);
    tidy();
    apb(1'b1, `OFF_CTRL, 32'h10);
    ph(3'h4, 6);
    chk("reverse on", 32'(mact), 32'h1);
    ph(3'h3, 6);
    ph(3'h2, 6);
    ph(3'h0, 6);
    chk("reverse off", 32'(mact), 32'h0);
    tidy();
  endtask
  task automatic t_qual();
    apb(1'b1, `OFF_CTRL, 32'h20);
    ph(3'h2, 6);
    chk("no qualifier", 32'(mact), 32'h0);
    tidy();
    apb(1'b1, `OFF_CTRL, 32'h20);
    qual <= 1'b1;
    cyc(3);
    ph(3'h2, 6);
    chk("qualified", 32'(mact), 32'h1);
    qual <= 1'b0;
    tidy();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    bad_count++;
    results();
  end
  initial begin
    {nrst, psel, penable, pwrite, qual, safe, ovr} = '0;
    {paddr, pwdata, phase} = '0;
    bad_count = 0;
    samples_checked = 0;
    ce = 1'b1;
    cyc(5);
    nrst <= 1'b1;
    cyc(5);
    t_regs();
    t_cycle();
    t_simul();
    t_total();
    t_dir();
    t_qual();
    results();
  end
endmodule
`default_nettype wire
